// [include/fcl_pkg.sv]
// Package for the fan control limit register bank: offsets, reset values,
// field positions, timing constants and the packed carriers.
// Assumes one 125 MHz clock and a plain strobe register port.
package fcl_pkg;

  // ****************************************************************
  // Register map (8-bit offsets on the register port)
  // ****************************************************************
  localparam logic [7:0] FCL_OFS_FLOOR1 = 8'h64;
  localparam logic [7:0] FCL_OFS_FLOOR2 = 8'h65;
  localparam logic [7:0] FCL_OFS_FLOOR3 = 8'h66;
  localparam logic [7:0] FCL_OFS_START_R1 = 8'h67;
  localparam logic [7:0] FCL_OFS_START_LOC = 8'h68;
  localparam logic [7:0] FCL_OFS_START_R2 = 8'h69;
  localparam logic [7:0] FCL_OFS_LIMIT_R1 = 8'h6A;
  localparam logic [7:0] FCL_OFS_LIMIT_LOC = 8'h6B;
  localparam logic [7:0] FCL_OFS_LIMIT_R2 = 8'h6C;
  localparam logic [7:0] FCL_OFS_HYST_R1L = 8'h6D;
  localparam logic [7:0] FCL_OFS_HYST_R2 = 8'h6E;
  localparam logic [7:0] FCL_OFS_ACOUSTIC2 = 8'hA0;
  localparam logic [7:0] FCL_OFS_CONFIG = 8'hA1;
  localparam logic [7:0] FCL_OFS_STATUS = 8'hA2;
  localparam logic [7:0] FCL_OFS_IRQ_CLR = 8'hA3;
  localparam logic [7:0] FCL_OFS_IRQ_EN = 8'hA4;
  localparam logic [7:0] FCL_OFS_DUTY1 = 8'hA5;
  localparam logic [7:0] FCL_OFS_DUTY2 = 8'hA6;
  localparam logic [7:0] FCL_OFS_DUTY3 = 8'hA7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] FCL_RST_FLOOR = 8'h80;
  localparam logic [7:0] FCL_RST_START = 8'h5A;
  localparam logic [7:0] FCL_RST_LIMIT = 8'h64;
  localparam logic [7:0] FCL_RST_HYST_R1L = 8'h44;
  localparam logic [7:0] FCL_RST_HYST_R2 = 8'h40;
  localparam logic [7:0] FCL_RST_ACOUSTIC2 = 8'h00;
  localparam logic [7:0] FCL_RST_CONFIG = 8'h00;
  localparam logic [7:0] FCL_ZERO8 = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FCL_ACOU_LOC_SMOOTH = 3;  // Acoustic 2 bit 3
  localparam int FCL_ACOU_R2_RATE_LO = 4;  // Acoustic 2 [6:4]
  localparam int FCL_ACOU_LOC_RATE_LO = 0; // Acoustic 2 [2:0]
  localparam int FCL_CFG_LOCK = 0;         // Config: lock bit
  localparam int FCL_CFG_AUTO = 1;         // Config: automatic mode
  localparam int FCL_CFG_PIN_OUT = 2;      // Config: overtemp pin is output
  localparam int FCL_CFG_FLOOR_SEL1 = 3;   // Config [5:3] floor selects
  localparam int FCL_CFG_SLOW_RAMP = 7;    // Config: slower ramp table
  localparam int FCL_HYST_LOC_LO = 0;
  localparam int FCL_HYST_R1_LO = 4;
  localparam int FCL_HYST_R2_LO = 4;

  localparam logic [7:0] FCL_LIMIT_DISABLE = 8'h80;
  localparam logic [7:0] FCL_DUTY_FULL = 8'hFF;
  localparam logic [7:0] FCL_SPAN_DEG = 8'h20; // Fixed span above start

  // ****************************************************************
  // Timing: one ramp time slot; full scale 255 steps over 37.5 s
  // ****************************************************************
  localparam real FCL_CLK_MHZ = 125.0;
  localparam real FCL_SLOT_FAST_MS = 147.0;  // ~37.5 s / 255
  localparam real FCL_SLOT_SLOW_MS = 204.7;  // ~52.2 s / 255
  localparam int FCL_SLOT_FAST_CYC = int'(FCL_SLOT_FAST_MS * 1000.0
                                          * FCL_CLK_MHZ);
  localparam int FCL_SLOT_SLOW_CYC = int'(FCL_SLOT_SLOW_MS * 1000.0
                                          * FCL_CLK_MHZ);

  // Channel indices
  localparam int FCL_CH_R1 = 0;
  localparam int FCL_CH_LOC = 1;
  localparam int FCL_CH_R2 = 2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fcl_bus_t;

  typedef struct packed {
    logic [7:0] r2;
    logic [7:0] loc;
    logic [7:0] r1;
  } fcl_temps_t;

  typedef enum logic [1:0] {
    FCL_ZONE_OFF = 2'b00,
    FCL_ZONE_FLOOR = 2'b01,
    FCL_ZONE_RUN = 2'b10
  } fcl_zone_t;

  // Ramp code to time-slot increment
  function automatic logic [7:0] fcl_slot_step(input logic [2:0] code);
    case (code)
      3'h0: fcl_slot_step = 8'h01;
      3'h1: fcl_slot_step = 8'h02;
      3'h2: fcl_slot_step = 8'h03;
      3'h3: fcl_slot_step = 8'h04;
      3'h4: fcl_slot_step = 8'h08;
      3'h5: fcl_slot_step = 8'h0C;
      3'h6: fcl_slot_step = 8'h18;
      default: fcl_slot_step = 8'h30;
    endcase
  endfunction

endpackage

// [rtl/fcl_limit_regs.sv]
// Fan control limit register bank with automatic control and fail-safe.
// Assumes temperatures arrive as unsigned degrees with a one-cycle
// conversion-done pulse, all synchronous to i_sys_clk.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module fcl_limit_regs
  import fcl_pkg::*;
(
  input wire logic i_sys_clk,          // 125 MHz clock
  input wire logic i_nrst,             // Sync reset, active low
  input wire fcl_bus_t i_bus,          // Register request
  output logic [7:0] o_rdata,          // Read data, cycle after read
  input wire fcl_temps_t i_temps,      // Measured temperatures
  input wire logic i_conv_done,        // New conversion pulse
  input wire logic [7:0] i_manual_duty, // Duty when not automatic
  output logic [7:0] o_duty1,          // Fan drive output 1 duty
  output logic [7:0] o_duty2,          // Fan drive output 2 duty
  output logic [7:0] o_duty3,          // Fan drive output 3 duty
  output logic o_overtemp_pin_o,       // Overtemp pin level (low)
  output logic o_overtemp_pin_oe,      // Overtemp pin enable
  output logic o_irq                   // Level interrupt
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] floor_reg [3];
  logic [7:0] start_reg [3];
  logic [7:0] limit_reg [3];
  logic [7:0] hyst_r1l_reg;
  logic [7:0] hyst_r2_reg;
  logic [7:0] acoustic_reg;
  logic [7:0] config_reg;
  logic [2:0] status_reg;
  logic [2:0] irq_en_reg;
  logic [2:0] hot_reg;
  logic [2:0] failsafe_reg;
  fcl_zone_t zone_reg [3];
  logic [7:0] target_reg [3];
  logic [31:0] slot_cnt_reg;
  logic [7:0] smooth_reg;

  logic locked;
  logic auto_mode;
  logic wr_ok_locked;
  logic [3:0] hyst [3];
  logic [7:0] temp [3];
  logic any_failsafe;
  logic slot;
  logic [31:0] slot_len;
  logic [7:0] ramp_duty [3];
  logic [2:0] events;
  logic [2:0] fs_prev_reg;
  logic [2:0] clr_bits;

  assign locked = config_reg[FCL_CFG_LOCK];
  assign auto_mode = config_reg[FCL_CFG_AUTO];
  assign wr_ok_locked = i_bus.wr && !locked;
  assign temp[FCL_CH_R1] = i_temps.r1;
  assign temp[FCL_CH_LOC] = i_temps.loc;
  assign temp[FCL_CH_R2] = i_temps.r2;
  // Per-channel hysteresis nibbles
  assign hyst[FCL_CH_R1] = hyst_r1l_reg[FCL_HYST_R1_LO +: 4];
  assign hyst[FCL_CH_LOC] = hyst_r1l_reg[FCL_HYST_LOC_LO +: 4];
  assign hyst[FCL_CH_R2] = hyst_r2_reg[FCL_HYST_R2_LO +: 4];

  // Saturating subtract so small limits do not wrap
  function automatic logic [7:0] fcl_sub_sat(input logic [7:0] a,
                                            input logic [3:0] b);
    fcl_sub_sat = (a > {4'h0, b}) ? a - {4'h0, b} : FCL_ZERO8;
  endfunction

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Floor duty registers freeze while automatic mode runs
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < 3; i++) floor_reg[i] <= FCL_RST_FLOOR;
    end else if (i_bus.wr && !auto_mode) begin
      if (i_bus.addr == FCL_OFS_FLOOR1) floor_reg[0] <= i_bus.wdata;
      if (i_bus.addr == FCL_OFS_FLOOR2) floor_reg[1] <= i_bus.wdata;
      if (i_bus.addr == FCL_OFS_FLOOR3) floor_reg[2] <= i_bus.wdata;
    end
  end

  // Lockable start temperatures, limits, hysteresis and acoustics
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < 3; i++) begin
        start_reg[i] <= FCL_RST_START;
        limit_reg[i] <= FCL_RST_LIMIT;
      end
      hyst_r1l_reg <= FCL_RST_HYST_R1L;
      hyst_r2_reg <= FCL_RST_HYST_R2;
      acoustic_reg <= FCL_RST_ACOUSTIC2;
    end else if (wr_ok_locked) begin
      case (i_bus.addr)
        FCL_OFS_START_R1: start_reg[0] <= i_bus.wdata;
        FCL_OFS_START_LOC: start_reg[1] <= i_bus.wdata;
        FCL_OFS_START_R2: start_reg[2] <= i_bus.wdata;
        FCL_OFS_LIMIT_R1: limit_reg[0] <= i_bus.wdata;
        FCL_OFS_LIMIT_LOC: limit_reg[1] <= i_bus.wdata;
        FCL_OFS_LIMIT_R2: limit_reg[2] <= i_bus.wdata;
        FCL_OFS_HYST_R1L: hyst_r1l_reg <= i_bus.wdata;
        FCL_OFS_HYST_R2: hyst_r2_reg <= i_bus.wdata;
        FCL_OFS_ACOUSTIC2: acoustic_reg <= i_bus.wdata;
        default: ;
      endcase
    end
  end

  // Configuration; the lock bit is sticky once set, only reset clears it
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      config_reg <= FCL_RST_CONFIG;
    end else if (i_bus.wr && i_bus.addr == FCL_OFS_CONFIG) begin
      config_reg <= i_bus.wdata | {7'h00, locked};
    end
  end

  // ****************************************************************
  // Time slot divider
  // ****************************************************************
  assign slot_len = config_reg[FCL_CFG_SLOW_RAMP] ?
                    32'(FCL_SLOT_SLOW_CYC) : 32'(FCL_SLOT_FAST_CYC);
  assign slot = (slot_cnt_reg >= slot_len - 32'h1);

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst || slot) begin
      slot_cnt_reg <= 32'h0;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 32'h1;
    end
  end

  // ****************************************************************
  // Control loop, evaluated on each conversion
  // ****************************************************************
  // Local smoothing: average new reading with the previous smoothed value
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      smooth_reg <= FCL_ZERO8;
    end else if (i_conv_done) begin
      smooth_reg <= acoustic_reg[FCL_ACOU_LOC_SMOOTH] ?
                    8'((({1'b0, smooth_reg} + {1'b0, i_temps.loc}) >> 1))
                    : i_temps.loc;
    end
  end

  // Over-limit compare with hysteresis release, and pin compare
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      failsafe_reg <= 3'h0;
      hot_reg <= 3'h0;
    end else if (i_conv_done) begin
      for (int i = 0; i < 3; i++) begin
        if (limit_reg[i] == FCL_LIMIT_DISABLE) begin
          failsafe_reg[i] <= 1'b0;
        end else if (temp[i] > limit_reg[i]) begin
          failsafe_reg[i] <= 1'b1;
        end else if (temp[i] < fcl_sub_sat(limit_reg[i], hyst[i])) begin
          failsafe_reg[i] <= 1'b0;
        end
        // A disabled limit keeps the pin quiet as well as the fail-safe
        hot_reg[i] <= (temp[i] > limit_reg[i]) &&
                      (limit_reg[i] != FCL_LIMIT_DISABLE);
      end
    end
  end

  assign any_failsafe = |failsafe_reg;

  // Start zone per channel; output n follows channel n
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < 3; i++) begin
        zone_reg[i] <= FCL_ZONE_OFF;
        target_reg[i] <= FCL_ZERO8;
      end
    end else if (i_conv_done) begin
      for (int i = 0; i < 3; i++) begin
        logic [7:0] t;
        logic [15:0] span_duty;
        t = (i == FCL_CH_LOC) ? smooth_reg : temp[i];
        span_duty = 16'h0;
        if (t > start_reg[i]) begin
          zone_reg[i] <= FCL_ZONE_RUN;
          span_duty = 16'(floor_reg[i]) + 16'(t - start_reg[i]) *
                      16'(FCL_DUTY_FULL - floor_reg[i]) / 16'(FCL_SPAN_DEG);
          target_reg[i] <= (span_duty > 16'(FCL_DUTY_FULL)) ?
                           FCL_DUTY_FULL : span_duty[7:0];
        end else if (t <= fcl_sub_sat(start_reg[i], hyst[i])) begin
          zone_reg[i] <= FCL_ZONE_OFF;
          target_reg[i] <= config_reg[FCL_CFG_FLOOR_SEL1 + i] ?
                           floor_reg[i] : FCL_ZERO8;
        end else begin
          zone_reg[i] <= FCL_ZONE_FLOOR;
          target_reg[i] <= floor_reg[i];
        end
      end
    end
  end

  // ****************************************************************
  // Ramp limiters; output 1 always jumps to target, output 3 uses the remote 2 rate, 2 the local one
  // ****************************************************************
  for (genvar g = 0; g < 3; g++) begin : g_ramp
    fcl_ramp u_ramp (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_slot(slot),
      .i_bypass(!auto_mode || g == FCL_CH_R1),
      .i_code((g == FCL_CH_R2) ?
              acoustic_reg[FCL_ACOU_R2_RATE_LO +: 3] :
              acoustic_reg[FCL_ACOU_LOC_RATE_LO +: 3]),
      .i_target(auto_mode ? target_reg[g] : i_manual_duty),
      .o_duty(ramp_duty[g])
    );
  end

  // Fail-safe overrides the ramp so cooling is never delayed
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_duty1 <= FCL_ZERO8;
      o_duty2 <= FCL_ZERO8;
      o_duty3 <= FCL_ZERO8;
    end else begin
      o_duty1 <= any_failsafe ? FCL_DUTY_FULL : ramp_duty[0];
      o_duty2 <= any_failsafe ? FCL_DUTY_FULL : ramp_duty[1];
      o_duty3 <= any_failsafe ? FCL_DUTY_FULL : ramp_duty[2];
    end
  end

  // Open-drain overtemp pin: enable only while pulling low
  assign o_overtemp_pin_o = 1'b0;
  assign o_overtemp_pin_oe = config_reg[FCL_CFG_PIN_OUT] && |hot_reg;

  // ****************************************************************
  // Interrupts: fail-safe entry per channel; set wins over clear
  // ****************************************************************
  // Entry is the rising edge of the fail-safe, so a held fail-safe
  // can be cleared once and does not re-raise the bit every cycle
  assign events = failsafe_reg & ~fs_prev_reg;
  assign clr_bits = (i_bus.wr && i_bus.addr == FCL_OFS_IRQ_CLR) ?
                    i_bus.wdata[2:0] : 3'h0;

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      status_reg <= 3'h0;
      fs_prev_reg <= 3'h0;
    end else begin
      fs_prev_reg <= failsafe_reg;
      status_reg <= (status_reg & ~clr_bits) | events;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      irq_en_reg <= 3'h0;
    end else if (i_bus.wr && i_bus.addr == FCL_OFS_IRQ_EN) begin
      irq_en_reg <= i_bus.wdata[2:0];
    end
  end

  assign o_irq = |(status_reg & irq_en_reg);

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_rdata <= FCL_ZERO8;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        FCL_OFS_FLOOR1: o_rdata <= floor_reg[0];
        FCL_OFS_FLOOR2: o_rdata <= floor_reg[1];
        FCL_OFS_FLOOR3: o_rdata <= floor_reg[2];
        FCL_OFS_START_R1: o_rdata <= start_reg[0];
        FCL_OFS_START_LOC: o_rdata <= start_reg[1];
        FCL_OFS_START_R2: o_rdata <= start_reg[2];
        FCL_OFS_LIMIT_R1: o_rdata <= limit_reg[0];
        FCL_OFS_LIMIT_LOC: o_rdata <= limit_reg[1];
        FCL_OFS_LIMIT_R2: o_rdata <= limit_reg[2];
        FCL_OFS_HYST_R1L: o_rdata <= hyst_r1l_reg;
        FCL_OFS_HYST_R2: o_rdata <= hyst_r2_reg;
        FCL_OFS_ACOUSTIC2: o_rdata <= acoustic_reg;
        FCL_OFS_CONFIG: o_rdata <= config_reg;
        FCL_OFS_STATUS: o_rdata <= {5'h00, status_reg};
        FCL_OFS_IRQ_EN: o_rdata <= {5'h00, irq_en_reg};
        FCL_OFS_DUTY1: o_rdata <= o_duty1;
        FCL_OFS_DUTY2: o_rdata <= o_duty2;
        FCL_OFS_DUTY3: o_rdata <= o_duty3;
        default: o_rdata <= FCL_ZERO8;
      endcase
    end else begin
      o_rdata <= FCL_ZERO8;
    end
  end

endmodule // fcl_limit_regs

// [rtl/fcl_ramp.sv]
// Rate limiter for one fan drive output.
// Moves the duty toward its target by a step on each slot pulse.
`timescale 1ns/1ps
module fcl_ramp
  import fcl_pkg::*;
(
  input wire logic i_sys_clk,       // System clock
  input wire logic i_nrst,          // Sync reset, active low
  input wire logic i_slot,          // One-cycle slot pulse
  input wire logic i_bypass,        // Jump straight to target
  input wire logic [2:0] i_code,    // Ramp-rate code
  input wire logic [7:0] i_target,  // Wanted duty
  output logic [7:0] o_duty         // Ramped duty
);

  logic [7:0] step;
  logic [8:0] up_sum;

  assign step = fcl_slot_step(i_code);
  assign up_sum = {1'b0, o_duty} + {1'b0, step};

  // Step toward target, clamping so no overshoot
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_duty <= FCL_ZERO8;
    end else if (i_bypass) begin
      o_duty <= i_target;
    end else if (i_slot) begin
      if (i_target > o_duty) begin
        o_duty <= (up_sum[7:0] > i_target || up_sum[8]) ?
                  i_target : up_sum[7:0];
      end else if (i_target < o_duty) begin
        o_duty <= (o_duty - i_target < step) ?
                  i_target : o_duty - step;
      end
    end
  end

endmodule // fcl_ramp

// [test/fcl_fan_model.sv]
// Model of the sensors and fans beyond the register bank.
// Assumes the bench sets temperatures; the overtemp line has a pull-up.
`timescale 1ns/1ps
module fcl_fan_model
  import fcl_pkg::*;
(
  input wire logic i_sys_clk,    // Clock
  input wire logic i_nrst,       // Sync reset, active low
  input wire fcl_temps_t i_want, // Temperatures to report
  input wire logic i_fire,       // End a conversion
  input wire logic i_pin_o,      // Pin level from device
  input wire logic i_pin_oe,     // Pin enable from device
  output fcl_temps_t o_temps,    // Reported temperatures
  output logic o_conv_done,      // One-cycle new-data pulse
  output logic o_pin_level       // Resolved overtemp line
);
  // Level tracks the sensor freely; only the pulse marks new data
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_temps <= '0;
      o_conv_done <= 1'b0;
    end else begin
      o_temps <= i_want;
      o_conv_done <= i_fire;
    end
  end
  // Open drain with pull-up: released line reads high
  assign o_pin_level = i_pin_oe ? i_pin_o : 1'b1;
endmodule // fcl_fan_model

// [test/fcl_limit_asserts.sv]
// Checker for the fan limit register bank, bound to its top module.
// Assumes one clock domain and the carriers of the package.
`timescale 1ns/1ps
module fcl_limit_asserts
  import fcl_pkg::*;
(
  input wire logic i_sys_clk,           // Clock
  input wire logic i_nrst,              // Sync reset, active low
  input wire fcl_bus_t i_bus,           // Register request
  input wire logic [7:0] o_rdata,       // Read data
  input wire logic i_conv_done,         // Conversion pulse
  input wire logic [7:0] i_manual_duty, // Manual duty
  input wire logic [7:0] o_duty1,       // Duty 1
  input wire logic [7:0] o_duty2,       // Duty 2
  input wire logic [7:0] o_duty3,       // Duty 3
  input wire logic o_overtemp_pin_o,    // Pin level
  input wire logic o_overtemp_pin_oe,   // Pin enable
  input wire logic o_irq                // Interrupt
);
  // ********************
  // Shadow state
  // ********************
  logic lock_reg;
  logic [7:0] start_reg;
  logic full;
  assign full = (o_duty1 == FCL_DUTY_FULL) && (o_duty2 == FCL_DUTY_FULL)
                && (o_duty3 == FCL_DUTY_FULL);
  // Only one start register is mirrored: enough to see a leaky lock
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      lock_reg <= 1'b0;
      start_reg <= FCL_RST_START;
    end else if (i_bus.wr) begin
      if (i_bus.addr == FCL_OFS_CONFIG && i_bus.wdata[FCL_CFG_LOCK])
        lock_reg <= 1'b1;
      if (i_bus.addr == FCL_OFS_START_R1 && !lock_reg)
        start_reg <= i_bus.wdata;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // ********************
  // Properties
  // ********************
  chk_pin_low: assert property (
    o_overtemp_pin_oe |-> !o_overtemp_pin_o)
    else $error("overtemp pin enabled but not low");
  chk_full_duty: assert property (
    o_overtemp_pin_oe && $past(o_overtemp_pin_oe) |-> full)
    else $error("fail-safe active without full duty");
  chk_pin_cause: assert property (
    $rose(o_overtemp_pin_oe) |-> $past(i_conv_done) || $past(i_bus.wr))
    else $error("overtemp pin rose with no conversion");
  chk_hold_full: assert property (
    o_overtemp_pin_oe && !i_conv_done && !i_bus.wr |=> o_overtemp_pin_oe)
    else $error("fail-safe released between conversions");
  chk_lock_hold: assert property (
    i_bus.rd && i_bus.addr == FCL_OFS_START_R1 |=> o_rdata == start_reg)
    else $error("start register wrong or written under lock");
  chk_irq_cause: assert property (
    $rose(o_irq) |-> $past(i_conv_done) || $past(i_conv_done, 2)
    || $past(i_bus.wr) || $past(i_bus.wr, 2))
    else $error("interrupt rose with no cause");
  chk_irq_clear: assert property (
    i_bus.wr && i_bus.addr == FCL_OFS_IRQ_CLR && i_bus.wdata == 8'hFF
    && !i_conv_done && !$past(i_conv_done) ##1 !i_conv_done |=> !o_irq)
    else $error("interrupt stayed after full clear");
  chk_duty_still: assert property (
    !i_conv_done && !$past(i_conv_done) && !$past(i_conv_done, 2)
    && !i_bus.wr && !$past(i_bus.wr) && !$past(i_bus.wr, 2)
    && $stable(i_manual_duty)
    && $past(i_manual_duty) == $past(i_manual_duty, 2)
    && $past(i_nrst) && $past(i_nrst, 2) |=> $stable(o_duty1))
    else $error("duty 1 moved with no new input");
endmodule // fcl_limit_asserts

bind fcl_limit_regs fcl_limit_asserts u_chk (.i_sys_clk, .i_nrst, .i_bus,
  .o_rdata, .i_conv_done, .i_manual_duty, .o_duty1, .o_duty2, .o_duty3,
  .o_overtemp_pin_o, .o_overtemp_pin_oe, .o_irq);

// [test/tb_top.sv]
// Self-checking bench for the fan limit register bank.
// Assumes the checker is bound and the fan model feeds temperatures.
`timescale 1ns/1ps
module tb_top;
  import fcl_pkg::*;
  logic i_sys_clk, i_nrst, pin_o, pin_oe, o_irq, conv, fire, pin_lvl;
  logic rd_pend;
  fcl_bus_t i_bus;
  fcl_temps_t temps, want;
  logic [7:0] o_rdata, o_duty1, o_duty2, o_duty3, manual, m;
  logic [31:0] lfsr;
  logic [7:0] exp_q[$];
  int bad_count, checks_done, cycles;
  logic [7:0] map_a [13] = '{8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69,
    8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'hA0, 8'h50};
  logic [7:0] map_r [13] = '{8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A,
    8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00};

  fcl_limit_regs dut (.i_sys_clk, .i_nrst, .i_bus, .o_rdata,
    .i_temps(temps), .i_conv_done(conv), .i_manual_duty(manual),
    .o_duty1, .o_duty2, .o_duty3, .o_overtemp_pin_o(pin_o),
    .o_overtemp_pin_oe(pin_oe), .o_irq);
  fcl_fan_model fans (.i_sys_clk, .i_nrst, .i_want(want), .i_fire(fire),
    .i_pin_o(pin_o), .i_pin_oe(pin_oe), .o_temps(temps),
    .o_conv_done(conv), .o_pin_level(pin_lvl));

  // ********************
  // Tasks
  // ********************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  // Strobes stay up until the next call, so back-to-back needs no gap
  task automatic op(input logic [7:0] a, input logic [7:0] d,
                    input logic w, input logic r);
    i_bus <= '{a, d, w, r};
    @(posedge i_sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(a, d, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    op(a, 8'h00, 1'b0, 1'b1);
  endtask
  task automatic idle(input int n);
    op(8'h00, 8'h00, 1'b0, 1'b0);
    repeat (n - 1) @(posedge i_sys_clk);
  endtask
  // New remote 1 reading, then time for the two-edge forcing path
  task automatic heat(input logic [7:0] r1);
    want <= '{8'h20, 8'h20, r1};
    fire <= 1'b1;
    idle(1);
    fire <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
  endtask

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  // Read data stands only in the cycle after the strobe
  always @(posedge i_sys_clk) rd_pend <= i_nrst && i_bus.rd;
  always @(negedge i_sys_clk) if (rd_pend) check(o_rdata, exp_q.pop_front());
  // Hang guard
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    i_nrst = 1'b0;
    i_bus = '0;
    manual = 8'h00;
    want = '0;
    fire = 1'b0;
    rd_pend = 1'b0;
    lfsr = 32'd90601;
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (6) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 13; i++) rd(map_a[i], map_r[i]);
    for (int i = 0; i < 11; i++) begin
      m = rnd();
      wr(map_a[i], m);
      rd(map_a[i], m);
    end
    for (int i = 0; i < 11; i++) wr(map_a[i], map_r[i]);
    for (int c = 0; c < 8; c++) begin
      wr(FCL_OFS_ACOUSTIC2, {1'b0, c[2:0], 1'b1, c[2:0]});
      rd(FCL_OFS_ACOUSTIC2, {1'b0, c[2:0], 1'b1, c[2:0]});
    end
    for (int i = 0; i < 4; i++) begin
      m = rnd();
      manual <= m;
      idle(3);
      check(o_duty1, m);
    end
    // Automatic mode, floor select off then on
    wr(FCL_OFS_FLOOR1, 8'h40);
    wr(FCL_OFS_START_R1, 8'h40);
    wr(FCL_OFS_IRQ_EN, 8'h07);
    wr(FCL_OFS_CONFIG, 8'h06);
    wr(FCL_OFS_FLOOR1, 8'h99);
    rd(FCL_OFS_FLOOR1, 8'h40);
    heat(8'h20);
    check(o_duty1, 8'h00);
    wr(FCL_OFS_CONFIG, 8'h0E);
    heat(8'h20);
    check(o_duty1, 8'h40);
    heat(8'h50);
    check({7'h00, o_duty1 > 8'h40}, 8'h01);
    // Hot reading without a conversion pulse changes nothing
    want <= '{8'h20, 8'h20, 8'h70};
    idle(6);
    check({7'h00, pin_oe}, 8'h00);
    heat(8'h70);
    check(o_duty1 & o_duty2 & o_duty3, 8'hFF);
    check({7'h00, pin_lvl, o_irq}, 8'h01);
    rd(FCL_OFS_STATUS, 8'h01);
    heat(8'h60);
    check(o_duty1 & o_duty3, 8'hFF);
    heat(8'h5F);
    check({7'h00, pin_lvl}, 8'h01);
    heat(8'h20);
    check(o_duty1, 8'h40);
    wr(FCL_OFS_IRQ_CLR, 8'hFF);
    idle(3);
    check({7'h00, o_irq}, 8'h00);
    // Masked event still latches status
    wr(FCL_OFS_IRQ_EN, 8'h00);
    heat(8'h70);
    check({7'h00, o_irq}, 8'h00);
    rd(FCL_OFS_STATUS, 8'h01);
    heat(8'h20);
    wr(FCL_OFS_IRQ_CLR, 8'hFF);
    wr(FCL_OFS_LIMIT_R1, FCL_LIMIT_DISABLE);
    heat(8'h90);
    check({7'h00, pin_oe}, 8'h00);
    rd(FCL_OFS_STATUS, 8'h00);
    // Lock freezes the limit side of the map
    wr(FCL_OFS_CONFIG, 8'h0F);
    wr(FCL_OFS_START_R1, 8'h11);
    wr(FCL_OFS_LIMIT_LOC, 8'h11);
    wr(FCL_OFS_ACOUSTIC2, 8'h11);
    rd(FCL_OFS_START_R1, 8'h40);
    rd(FCL_OFS_LIMIT_LOC, 8'h64);
    rd(FCL_OFS_ACOUSTIC2, 8'h7F);
    idle(4);
    close_out();
  end
endmodule // tb_top
